/* File: tdc_pkg.sv */
// How it works
// - Odd unit codes 1..31 pick one of sixteen tape units, ascending order.
// - Binary mode with bit 23 set moves at most word-count words between memory and tape.
// - Bit 21 set means binary, clear means alphanumeric, both directions.
// - On reads bit 22 clear reads forward, set reads backward.
// - Bit 23 enables the word count field.
// - Bit 24 set means tape read into memory.
// - Core address counts up on forward reads, down on backward reads.
// - Alpha read ends at record gap; word count may stop storing earlier.
// - Binary read with bit 23 set stops storing after word-count words.
// - Alpha write ends when a group mark is fetched from memory.
// - Binary write with bit 23 set ends after word count, then a record gap is written.
// - Result bits 3 to 24 copy the initiating descriptor.
// - Result bit 27 flags a tape mark (code 15), end of file.
// - Result bit 28 flags lateral or longitudinal parity error; bit 29 zero.
// - Read result address: last filled plus one, or start minus count minus one.
// - Write result address is last cell fetched plus one.
// - Group mark is memory character octal 37.
// - Even lateral parity alpha, odd binary; each record ends with parity char.
package tdc_pkg;

  // Descriptor, first field is bit 0 (most significant)
  typedef struct packed {
    logic flag;
    logic ident;
    logic present;
    logic [4:0] unit;
    logic [9:0] wcount;
    logic b18;
    logic b19;
    logic b20;
    logic binary;
    logic backward;
    logic wc_en;
    logic read;
    logic b25;
    logic b26;
    logic eof;
    logic perr;
    logic b29;
    logic [2:0] err;
    logic [14:0] addr;
  } tdc_desc_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [14:0] addr;
    logic [47:0] wdata;
  } tdc_mem_req_t;

  typedef struct packed {
    logic go;
    logic write;
    logic backward;
    logic binary;
  } tdc_tape_ctl_t;

  typedef enum logic [6:0] {
    TDC_IDLE = 7'h01,
    TDC_FETCH = 7'h02,
    TDC_EMIT = 7'h04,
    TDC_LPC = 7'h08,
    TDC_GAP = 7'h10,
    TDC_RECV = 7'h20,
    TDC_STORE = 7'h40
  } tdc_st_t;

  localparam logic [4:0] TDC_REG_DESC_LO = 5'h00;
  localparam logic [4:0] TDC_REG_DESC_HI = 5'h04;
  localparam logic [4:0] TDC_REG_RES_LO = 5'h08;
  localparam logic [4:0] TDC_REG_RES_HI = 5'h0C;
  localparam logic [4:0] TDC_REG_STATUS = 5'h10;
  localparam logic [5:0] TDC_GROUP_MARK = 6'h1F;
  localparam logic [5:0] TDC_TAPE_MARK = 6'h0F;
  localparam logic [2:0] TDC_LAST_CHAR = 3'h7;
  localparam logic [3:0] TDC_CHARS_WORD = 4'h8;
  localparam int TDC_CHAR_CYCLES = 16;

endpackage : tdc_pkg

/* File: tdc_pin_sync.sv */
`timescale 1ns/10ps
module tdc_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] stable_out
);
  import tdc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stab;
  } tdc_sync_t;

  tdc_sync_t q;
  tdc_sync_t n;

  // Stage one feeds only stage two; agreement filters one-edge glitches
  always_comb begin
    n = q;
    n.s1 = pin_in;
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.stab[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign stable_out = q.stab;

endmodule : tdc_pin_sync

/* File: tdc_unit_decode.sv */
`timescale 1ns/10ps
module tdc_unit_decode (
  input wire logic [4:0] code_in,
  output logic [15:0] sel_out,
  output logic valid_out
);
  import tdc_pkg::*;

  assign valid_out = code_in[0];
  for (genvar u = 0; u < 16; u++) begin : g_unit
    assign sel_out[u] = code_in[0] && (code_in[4:1] == 4'(u));
  end

endmodule : tdc_unit_decode

/* File: tdc_core.sv */
`timescale 1ns/10ps
module tdc_core #(
  parameter int CHAR_CYCLES = tdc_pkg::TDC_CHAR_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [2:0] std_err_in,
  output tdc_pkg::tdc_mem_req_t mem_req_out,
  input wire logic mem_ack_in,
  input wire logic [47:0] mem_rdata_in,
  output logic [15:0] unit_sel_out,
  output tdc_pkg::tdc_tape_ctl_t tape_ctl_out,
  output logic tape_wstb_out,
  output logic [6:0] tape_wdata_out,
  output logic tape_gap_out,
  input wire logic tape_rd_tgl_in,
  input wire logic [6:0] tape_rd_data_in,
  input wire logic tape_gap_in
);
  import tdc_pkg::*;

  if (CHAR_CYCLES < 2 || CHAR_CYCLES > 255) begin : g_bad
    $error("CHAR_CYCLES must lie in 2..255");
  end

  typedef struct packed {
    tdc_st_t st;
    tdc_desc_t desc;
    tdc_desc_t res;
    logic [14:0] addr;
    logic [9:0] words;
    logic [47:0] wbuf;
    logic [3:0] cidx;
    logic [6:0] lrc;
    logic perr;
    logic eof;
    logic xfer;
    logic first;
    logic [6:0] pend;
    logic [5:0] firstc;
    logic [1:0] nch;
    logic gap_seen;
    logic [7:0] div;
    logic tick;
    logic rx_last;
    logic gap_last;
    tdc_mem_req_t mem;
    tdc_tape_ctl_t ctl;
    logic [15:0] unit;
    logic wstb;
    logic [6:0] wdata;
    logic gapo;
    logic busy;
    logic done;
    logic uvalid;
    logic [31:0] rdata;
  } tdc_core_t;

  tdc_core_t q;
  tdc_core_t n;
  logic [15:0] dec_sel;
  logic dec_valid;
  logic [8:0] rx_s;

  tdc_unit_decode u_dec (
    .code_in(reg_wdata_in[12:8]),
    .sel_out(dec_sel),
    .valid_out(dec_valid)
  );

  tdc_pin_sync #(.W(9)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in({tape_gap_in, tape_rd_tgl_in, tape_rd_data_in}),
    .stable_out(rx_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    tdc_desc_t d;
    logic [6:0] c;
    logic [6:0] cand;
    logic [47:0] nw;
    logic [5:0] sh;
    logic rx_ev;
    logic gap_ev;
    logic wc_hit;
    logic gm_on;
    d = q.desc;
    c = rx_s[6:0];
    cand = q.desc.backward ? c : q.pend;
    nw = q.wbuf;
    sh = 6'(6'(TDC_CHARS_WORD - q.cidx) * 6'd6);
    rx_ev = rx_s[7] != q.rx_last;
    gap_ev = rx_s[8] && !q.gap_last;
    wc_hit = q.desc.wc_en && (q.words == q.desc.wcount);
    gm_on = !(q.desc.binary && q.desc.wc_en);
    n = q;
    n.wstb = 1'b0;
    n.gapo = 1'b0;
    n.tick = 1'b0;
    n.rx_last = rx_s[7];
    n.gap_last = rx_s[8];
    // Character clock from a divider, tape rate far below core rate
    if (q.div == 8'(CHAR_CYCLES - 1)) begin
      n.div = 8'h00;
      n.tick = 1'b1;
    end else begin
      n.div = q.div + 8'h01;
    end
    n.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        TDC_REG_DESC_LO: n.rdata = q.desc[31:0];
        TDC_REG_DESC_HI: n.rdata = {16'h0000, q.desc[47:32]};
        TDC_REG_RES_LO: n.rdata = q.res[31:0];
        TDC_REG_RES_HI: n.rdata = {16'h0000, q.res[47:32]};
        TDC_REG_STATUS: n.rdata = {29'h0, q.uvalid, q.done, q.busy};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // Writes while busy are dropped so the running descriptor stays intact
    if (reg_wr_in && !q.busy) begin
      if (reg_addr_in == TDC_REG_DESC_LO) begin
        n.desc[31:0] = reg_wdata_in;
      end else if (reg_addr_in == TDC_REG_DESC_HI) begin
        n.desc[47:32] = reg_wdata_in[15:0];
        d = n.desc;
        n.busy = 1'b1;
        n.done = 1'b0;
        n.addr = d.addr;
        n.words = 10'h000;
        n.cidx = 4'h0;
        n.lrc = 7'h00;
        n.perr = 1'b0;
        n.eof = 1'b0;
        n.xfer = 1'b1;
        n.first = 1'b1;
        n.nch = 2'h0;
        n.gap_seen = 1'b0;
        n.unit = dec_sel;
        n.uvalid = dec_valid;
        n.div = 8'h00;
        n.ctl.go = dec_valid;
        n.ctl.write = !d.read;
        n.ctl.backward = d.read && d.backward;
        n.ctl.binary = d.binary;
        n.st = d.read ? TDC_RECV : TDC_FETCH;
        if (!dec_valid) begin
          n.st = TDC_GAP;
        end
      end
    end
    case (q.st)
      TDC_IDLE: begin
      end
      TDC_FETCH: begin
        if (wc_hit) begin
          n.st = TDC_LPC;
        end else if (!q.mem.req) begin
          n.mem = '{req: 1'b1, we: 1'b0, addr: q.addr, wdata: 48'h0};
        end else if (mem_ack_in) begin
          n.mem.req = 1'b0;
          n.wbuf = mem_rdata_in;
          n.addr = q.addr + 15'h0001;
          n.words = q.words + 10'h001;
          n.cidx = 4'h0;
          n.st = TDC_EMIT;
        end
      end
      TDC_EMIT: begin
        if (q.tick) begin
          if (gm_on && q.wbuf[47:42] == TDC_GROUP_MARK) begin
            n.st = TDC_LPC;
          end else begin
            n.wstb = 1'b1;
            n.wdata = {^{q.ctl.binary, q.wbuf[47:42]}, q.wbuf[47:42]};
            n.lrc = q.lrc ^ n.wdata;
            n.wbuf = {q.wbuf[41:0], 6'h00};
            n.cidx = q.cidx + 4'h1;
            if (q.cidx[2:0] == TDC_LAST_CHAR) begin
              n.st = TDC_FETCH;
            end
          end
        end
      end
      TDC_LPC: begin
        if (q.tick) begin
          n.wstb = 1'b1;
          n.wdata = q.lrc;
          n.st = TDC_GAP;
        end
      end
      TDC_GAP: begin
        if (q.tick || !q.ctl.go || !q.ctl.write) begin
          n.gapo = q.ctl.go && q.ctl.write;
          n.res = q.desc;
          n.res.b25 = 1'b0;
          n.res.b26 = 1'b0;
          n.res.eof = q.eof;
          n.res.perr = q.perr;
          n.res.b29 = 1'b0;
          n.res.err = std_err_in;
          n.res.addr = q.ctl.backward ? q.addr - 15'h0001 : q.addr;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.ctl = '0;
          n.unit = 16'h0000;
          n.st = TDC_IDLE;
        end
      end
      TDC_RECV, TDC_STORE: begin
        if (rx_ev) begin
          n.nch = (q.nch == 2'h3) ? q.nch : q.nch + 2'h1;
          n.lrc = q.lrc ^ c;
          n.pend = c;
          if (q.first) begin
            n.first = 1'b0;
            n.firstc = c[5:0];
          end else begin
            if ((^cand) != q.ctl.binary) begin
              n.perr = 1'b1;
            end
            if (q.xfer) begin
              nw = q.ctl.backward ? {cand[5:0], q.wbuf[47:6]}
                                  : {q.wbuf[41:0], cand[5:0]};
              n.wbuf = nw;
              n.cidx = q.cidx + 4'h1;
              if (q.cidx[2:0] == TDC_LAST_CHAR) begin
                n.cidx = 4'h0;
                if (q.st == TDC_RECV) begin
                  n.mem = '{req: 1'b1, we: 1'b1, addr: q.addr, wdata: nw};
                  n.st = TDC_STORE;
                end
              end
            end
          end
        end
        if (gap_ev) begin
          n.gap_seen = 1'b1;
          if (q.lrc != 7'h00) begin
            n.perr = 1'b1;
          end
          if (q.nch == 2'h2 && (q.ctl.backward ? q.pend[5:0] : q.firstc)
              == TDC_TAPE_MARK) begin
            n.eof = 1'b1;
          end
        end
        if (q.st == TDC_STORE) begin
          if (mem_ack_in) begin
            n.mem.req = 1'b0;
            n.mem.we = 1'b0;
            n.addr = q.ctl.backward ? q.addr - 15'h0001 : q.addr + 15'h0001;
            n.words = q.words + 10'h001;
            if (q.desc.wc_en && (q.words + 10'h001) == q.desc.wcount) begin
              n.xfer = 1'b0;
            end
            n.st = TDC_RECV;
          end
        end else if (q.gap_seen) begin
          // Trailing part word is padded with zeros at the far end
          if (q.cidx != 4'h0 && q.xfer) begin
            nw = q.ctl.backward ? q.wbuf >> sh : q.wbuf << sh;
            n.mem = '{req: 1'b1, we: 1'b1, addr: q.addr, wdata: nw};
            n.cidx = 4'h0;
            n.st = TDC_STORE;
          end else begin
            n.st = TDC_GAP;
          end
        end
      end
      default: n.st = TDC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
      q.st <= TDC_IDLE;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign mem_req_out = q.mem;
  assign unit_sel_out = q.unit;
  assign tape_ctl_out = q.ctl;
  assign tape_wstb_out = q.wstb;
  assign tape_wdata_out = q.wdata;
  assign tape_gap_out = q.gapo;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_unit_onehot: assert property (
    q.ctl.go |-> $onehot(unit_sel_out)) else $error("unit select not one-hot");
  a_bin_count: assert property (
    (q.st == TDC_LPC && q.ctl.binary && q.desc.wc_en)
    |-> q.words == q.desc.wcount) else $error("binary write count wrong");
  a_mode_bin: assert property (
    q.ctl.go |-> tape_ctl_out.binary == q.desc.binary)
    else $error("mode differs from bit 21");
  a_back_read: assert property (
    tape_ctl_out.backward |-> q.desc.read && q.desc.backward)
    else $error("backward motion outside backward read");
  a_dir_ctl: assert property (
    q.ctl.go |-> tape_ctl_out.write == !q.desc.read)
    else $error("direction differs from bit 24");
  a_addr_step: assert property (
    (q.st == TDC_STORE && mem_ack_in && !q.ctl.backward)
    |=> q.addr == $past(q.addr) + 15'h0001) else $error("address not stepped");
  a_rd_stop: assert property (
    (q.st == TDC_RECV && q.desc.wc_en && q.words == q.desc.wcount
     && q.words != 10'h000) |-> !q.xfer) else $error("store past count");
  a_gm_end: assert property (
    (q.st == TDC_EMIT && q.tick && q.desc.wc_en == 1'b0
     && q.wbuf[47:42] == TDC_GROUP_MARK) |=> q.st == TDC_LPC ##1 !tape_wstb_out
    [*1] ##[1:1000] tape_wstb_out) else $error("group mark did not end");
  a_gap_after: assert property (
    (q.st == TDC_LPC && q.tick) |=> tape_wstb_out ##[1:1000] tape_gap_out)
    else $error("no gap after record");
  a_res_copy: assert property (
    $rose(q.done) |-> q.res[44:23] == q.desc[44:23])
    else $error("result bits 3-24 differ");
  a_res_back: assert property (
    ($rose(q.done) && $past(q.ctl.backward))
    |-> q.res.addr == q.addr - 15'h0001) else $error("backward address wrong");
  a_lat_par: assert property (
    ($past(q.st) == TDC_EMIT && tape_wstb_out)
    |-> (^tape_wdata_out) == q.ctl.binary) else $error("lateral parity wrong");

  c_write_done: cover property ($rose(q.done) && q.res.read == 1'b0);
  c_read_fwd: cover property ($rose(q.done) && q.res.read && !q.res.backward);
  c_read_back: cover property ($rose(q.done) && q.res.read && q.res.backward);
  c_eof: cover property ($rose(q.done) && q.res.eof);

endmodule : tdc_core

/* File: tdc_tape_model.sv */
`timescale 1ns/10ps
module tdc_tape_model (
  input wire logic clk_in,
  input wire tdc_pkg::tdc_mem_req_t mem_req_in,
  input wire logic tape_wstb_in,
  input wire logic [6:0] tape_wdata_in,
  input wire logic tape_gap_in,
  output logic mem_ack_out,
  output logic [47:0] mem_rdata_out,
  output logic tape_tgl_out,
  output logic [6:0] tape_data_out,
  output logic tape_gap_out
);
  import tdc_pkg::*;
  logic [47:0] mem [0:32767];
  logic [6:0] wq[$];
  int slow = 0;
  int wt = 0;
  int gaps = 0;
  int stores = 0;

  initial begin
    mem_ack_out = 1'b0;
    mem_rdata_out = 48'h0;
    tape_tgl_out = 1'b0;
    tape_data_out = 7'h00;
    tape_gap_out = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Core memory; slow answers stall fetch and store alike
  always @(posedge clk_in) begin
    mem_ack_out <= 1'b0;
    // Data only valid with ack, so it churns otherwise
    mem_rdata_out <= ~mem_rdata_out;
    if (mem_req_in.req && !mem_ack_out) begin
      if (wt < slow) begin
        wt <= wt + 1;
      end else begin
        wt <= 0;
        mem_ack_out <= 1'b1;
        if (mem_req_in.we) begin
          mem[mem_req_in.addr] <= mem_req_in.wdata;
          stores++;
        end else begin
          mem_rdata_out <= mem[mem_req_in.addr];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write head captures chars and gap pulses
  always @(posedge clk_in) begin
    if (tape_wstb_in) begin
      wq.push_back(tape_wdata_in);
    end
    if (tape_gap_in) begin
      gaps++;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read head: data settles well before each toggle, then a gap
  task automatic play(input logic [6:0] cs[$]);
    foreach (cs[i]) begin
      tape_data_out <= cs[i];
      repeat (6) @(posedge clk_in);
      tape_tgl_out <= ~tape_tgl_out;
      repeat (6) @(posedge clk_in);
    end
    // Released data lines must not look like a last char
    tape_data_out <= ~tape_data_out;
    tape_gap_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    tape_gap_out <= 1'b0;
  endtask : play
endmodule : tdc_tape_model

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import tdc_pkg::*;
  // Mode per kind: binary, read, backward, word count enable
  // writes keep read and backward clear
  localparam logic [3:0] MODES [8] = '{4'h9, 4'h0, 4'hD, 4'hF, 4'h4, 4'h4,
    4'hD, 4'h9};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [4:0] reg_addr_in = 5'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [2:0] std_err_in = 3'h0;
  tdc_mem_req_t mem_req_out;
  logic mem_ack_in;
  logic [47:0] mem_rdata_in;
  logic [15:0] unit_sel_out;
  tdc_tape_ctl_t tape_ctl_out;
  logic tape_wstb_out;
  logic [6:0] tape_wdata_out;
  logic tape_gap_out;
  logic tape_rd_tgl_in;
  logic [6:0] tape_rd_data_in;
  logic tape_gap_in;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] rs = 32'h986A;

  always #50 clk_in = ~clk_in;

  tdc_core #(.CHAR_CYCLES(4)) i_tdc_core (
    .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .std_err_in(std_err_in), .mem_req_out(mem_req_out),
    .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
    .unit_sel_out(unit_sel_out), .tape_ctl_out(tape_ctl_out),
    .tape_wstb_out(tape_wstb_out), .tape_wdata_out(tape_wdata_out),
    .tape_gap_out(tape_gap_out), .tape_rd_tgl_in(tape_rd_tgl_in),
    .tape_rd_data_in(tape_rd_data_in), .tape_gap_in(tape_gap_in));

  tdc_tape_model i_tdc_tape_model (
    .clk_in(clk_in), .mem_req_in(mem_req_out),
    .tape_wstb_in(tape_wstb_out), .tape_wdata_in(tape_wdata_out),
    .tape_gap_in(tape_gap_out), .mem_ack_out(mem_ack_in),
    .mem_rdata_out(mem_rdata_in), .tape_tgl_out(tape_rd_tgl_in),
    .tape_data_out(tape_rd_data_in), .tape_gap_out(tape_gap_in));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  // Backward reads rebuild each word from reversed arrival order
  function automatic logic [47:0] rev_chars(input logic [47:0] w);
    logic [47:0] r;
    r = 48'h0;
    for (int i = 0; i < 8; i++) r[6 * i +: 6] = w[47 - 6 * i -: 6];
    return r;
  endfunction : rev_chars

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : rd

  task automatic start(input tdc_desc_t d);
    wr(TDC_REG_DESC_LO, d[31:0]);
    wr(TDC_REG_DESC_HI, {16'h0, d[47:32]});
    #1;
    check(48'(unit_sel_out), d.unit[0] ? 48'h1 << d.unit[4:1] : 48'h0);
    // Go only for a valid unit; direction and mode follow the descriptor
    check(48'(tape_ctl_out), {44'h0, d.unit[0], !d.read, d.backward,
      d.binary});
  endtask : start

  task automatic finish(output tdc_desc_t r, output logic [31:0] s);
    logic [31:0] lo;
    int t;
    s = 32'h0;
    for (t = 0; t < 4000 && s[1] !== 1'b1; t++) rd(TDC_REG_STATUS, s);
    if (s[1] !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    rd(TDC_REG_RES_LO, lo);
    rd(TDC_REG_RES_HI, s);
    r = {s[15:0], lo};
    rd(TDC_REG_STATUS, s);
  endtask : finish

  // Hang guard, well past the longest expected run
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    wrap_up();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    tdc_desc_t d, r;
    logic [31:0] v, u, s;
    logic [47:0] w;
    logic [5:0] c;
    logic [6:0] lpc;
    logic [14:0] ea;
    logic [2:0] k;
    int kind, n, nw, i, j, rep;
    logic [6:0] eq[$];
    logic [47:0] ew[$];
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(TDC_REG_STATUS, s);
    check(48'(s), 48'h0);
    rd(5'h14, s);
    check(48'(s), 48'h0);
    for (rep = 0; rep < 2; rep++) begin
      for (kind = 0; kind < 8; kind++) begin
        v = rnd();
        d = '0;
        // marks set, bit 18 left clear
        d.flag = 1'b1;
        d.present = 1'b1;
        {d.binary, d.read, d.backward, d.wc_en} = MODES[kind];
        d.unit = {v[3:0], kind != 7};
        n = (kind == 5) ? 1 : int'(v[5:4]) + 1;
        nw = (kind == 2) ? n + 1 : n;
        k = d.read ? {v[10:9], 1'b1} : v[10:8];
        if (kind == 5) k = 3'h1;
        d.wcount = d.wc_en ? 10'(n) : v[27:18];
        d.addr = {2'b01, v[28:16]};
        i_tdc_tape_model.slow = int'(v[7:6]);
        i_tdc_tape_model.wq.delete();
        i_tdc_tape_model.gaps = 0;
        i_tdc_tape_model.stores = 0;
        eq.delete();
        ew.delete();
        for (j = 0; j < nw; j++) begin
          for (i = 0; i < 8; i++) begin
            u = rnd();
            // Alpha chars stay clear of the group mark
            c = d.binary ? u[5:0] : {1'b1, u[4:0]};
            if (kind == 5) c = TDC_TAPE_MARK;
            if (!d.binary && j == nw - 1 && i >= int'(k)) begin
              c = (i == int'(k) && !d.read) ? TDC_GROUP_MARK : 6'h00;
            end else begin
              eq.push_back({d.binary ? ~^c : ^c, c});
            end
            w[47 - 6 * i -: 6] = c;
          end
          ew.push_back(w);
          if (!d.read) i_tdc_tape_model.mem[d.addr + j] = w;
        end
        lpc = 7'h00;
        foreach (eq[i]) lpc ^= eq[i];
        if (kind == 6) eq[1] = eq[1] ^ 7'h40;
        if (d.backward) eq.push_front(lpc);
        else eq.push_back(lpc);
        @(posedge clk_in);
        std_err_in <= v[31:29];
        start(d);
        if (d.read) i_tdc_tape_model.play(eq);
        finish(r, s);
        check(48'(s[2:0]), {45'h0, d.unit[0], 2'b10});
        if (kind == 7) begin
          check(48'(i_tdc_tape_model.wq.size()), 48'h0);
        end else begin
          ea = d.backward ? d.addr - 15'(n) - 15'h1 : d.addr + 15'(n);
          check(48'(r[44:23]), 48'(d[44:23]));
          check({45'h0, r.eof, r.perr, r.b29},
            {45'h0, kind == 5, kind == 6, 1'b0});
          check(48'(r.err), 48'(std_err_in));
          check(48'(r.addr), 48'(ea));
          if (!d.read) begin
            check(48'(i_tdc_tape_model.gaps), 48'h1);
            check(48'(i_tdc_tape_model.wq.size()),
              48'(eq.size()));
            foreach (eq[i]) begin
              check(48'(i_tdc_tape_model.wq[i]), 48'(eq[i]));
            end
          end else begin
            check(48'(i_tdc_tape_model.stores), 48'(n));
            for (j = 0; j < n && kind != 6; j++) begin
              check(i_tdc_tape_model.mem[d.backward ? d.addr - j : d.addr + j],
                d.backward ? rev_chars(ew[j]) : ew[j]);
            end
          end
        end
      end
    end
    wrap_up();
  end
endmodule : tb_top
